// [bsa_pkg.sv]
// Constants shared by the bus-shunt addressing slave logic.
`default_nettype none
package bsa_pkg;
  localparam int unsigned CLK_MHZ        = 25;
  localparam int unsigned NORM_ENTRY_US  = 10;
  localparam int unsigned SLEEP_ENTRY_US = 10;
  localparam int unsigned REMOTE_WAKE_US = 30;
  localparam int unsigned LOCAL_WAKE_US  = 7;
  localparam int unsigned DOM_TIMEOUT_MS = 27;
  localparam int unsigned NORM_CYC       = NORM_ENTRY_US * CLK_MHZ;
  localparam int unsigned SLEEP_CYC      = SLEEP_ENTRY_US * CLK_MHZ;
  localparam int unsigned RWAKE_CYC      = REMOTE_WAKE_US * CLK_MHZ;
  localparam int unsigned LWAKE_CYC      = LOCAL_WAKE_US * CLK_MHZ;
  localparam int unsigned DOM_TO_CYC     = DOM_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int unsigned ADC_W          = 12;
  localparam int unsigned ADDR_W         = 6;
  localparam logic [ADC_W-1:0] THR_RST   = 12'h040;
  typedef enum logic [5:0] {
    M_IDLE  = 6'h01,
    M_ARMED = 6'h02,
    M_MEAS1 = 6'h04,
    M_MEAS2 = 6'h08,
    M_MEAS3 = 6'h10,
    M_DONE  = 6'h20
  } meas_e;
  typedef enum logic [3:0] {
    P_PWRUP   = 4'h1,
    P_SLEEP   = 4'h2,
    P_STANDBY = 4'h4,
    P_NORMAL  = 4'h8
  } phy_e;
endpackage : bsa_pkg
`default_nettype wire

// [sat_counter.sv]
// Saturating run-length counter used for the timing filters.
`timescale 1ns/1ps
`default_nettype none
module sat_counter #(
  parameter int unsigned LIMIT = 16
) (
  input  wire logic i_clk_sys,
  input  wire logic i_sys_rst,
  input  wire logic i_run,
  output logic      o_reached
);
  localparam int unsigned W = $clog2(LIMIT + 1);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic         next_reached;

  always_comb begin
    next_count = count;
    if (!i_run) begin
      next_count = '0;
    end else if (count != W'(LIMIT)) begin
      next_count = count + W'(1);
    end
    next_reached = i_run && (next_count == W'(LIMIT));
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      count     <= '0;
      o_reached <= 1'b0;
    end else begin
      count     <= next_count;
      o_reached <= next_reached;
    end
  end
endmodule : sat_counter
`default_nettype wire

// [bus_shunt_addressing.sv]
// Slave-side bus-shunt addressing sequencer and transceiver mode control.
`timescale 1ns/1ps
`default_nettype none
module bus_shunt_addressing
  import bsa_pkg::*;
#(
  parameter int unsigned DOM_TIMEOUT = DOM_TO_CYC
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_sys_rst,
  input  wire logic              i_assign_cmd,
  input  wire logic [ADDR_W-1:0] i_assign_addr,
  input  wire logic              i_break_start,
  input  wire logic              i_break_end,
  input  wire logic              i_adc_valid,
  input  wire logic [ADC_W-1:0]  i_adc_data,
  input  wire logic [ADC_W-1:0]  i_current_difference_threshold,
  input  wire logic              i_sleep_control_low,
  input  wire logic              i_bus_rx,
  input  wire logic              i_wake_n,
  input  wire logic              i_txd,
  output logic                   o_first_source_port_pin,
  output logic                   o_second_source_port_pin,
  output logic                   o_adc_start,
  output logic                   o_farthest,
  output logic                   o_addr_valid,
  output logic [ADDR_W-1:0]      o_node_addr,
  output logic                   o_addr_fail,
  output logic                   o_bus_tx,
  output logic                   o_rxd,
  output logic                   o_inhibit_output,
  output logic                   o_wake_flag,
  output logic [3:0]             o_phy_mode
);
  // Pins from the transceiver side cross into this domain through two stages.
  logic [1:0] slp_s, bus_s, wake_s;
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      slp_s  <= 2'h0;
      bus_s  <= 2'h3;
      wake_s <= 2'h3;
    end else begin
      slp_s  <= {slp_s[0], i_sleep_control_low};
      bus_s  <= {bus_s[0], i_bus_rx};
      wake_s <= {wake_s[0], i_wake_n};
    end
  end
  logic slp_hi, bus_dom, wake_act;
  assign slp_hi   = slp_s[1];
  assign bus_dom  = !bus_s[1];
  assign wake_act = !wake_s[1];

  logic norm_ok, sleep_ok, rwake_ok, lwake_ok, dom_to;
  sat_counter #(.LIMIT(NORM_CYC)) u_norm (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_run(slp_hi), .o_reached(norm_ok));
  sat_counter #(.LIMIT(SLEEP_CYC)) u_sleep (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_run(!slp_hi), .o_reached(sleep_ok));
  sat_counter #(.LIMIT(RWAKE_CYC)) u_rwake (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_run(bus_dom), .o_reached(rwake_ok));
  sat_counter #(.LIMIT(LWAKE_CYC)) u_lwake (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_run(wake_act), .o_reached(lwake_ok));
  sat_counter #(.LIMIT(DOM_TIMEOUT)) u_domto (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_run(!i_txd), .o_reached(dom_to));

  // Transceiver mode control.
  phy_e phy, next_phy;
  logic wake_flag, next_wake_flag, slp_hi_d, next_slp_hi_d;
  logic next_rxd, next_inh, next_tx;
  always_comb begin
    next_phy       = phy;
    next_wake_flag = wake_flag;
    next_slp_hi_d  = slp_hi;
    unique case (phy)
      P_PWRUP: begin
        if (norm_ok) next_phy = P_NORMAL;
      end
      P_SLEEP: begin
        if (rwake_ok || lwake_ok) begin
          next_phy       = P_STANDBY;
          next_wake_flag = 1'b1;
        end else if (norm_ok) begin
          next_phy       = P_NORMAL;
        end
      end
      P_STANDBY: begin
        if (slp_hi && !slp_hi_d) next_wake_flag = 1'b0;
        if (norm_ok) next_phy = P_NORMAL;
      end
      P_NORMAL: begin
        if (sleep_ok) next_phy = P_SLEEP;
      end
    endcase
    // Wake request shows on receive only until sleep control rises.
    next_rxd = (next_phy == P_STANDBY) ? !next_wake_flag :
               (next_phy == P_NORMAL) ? bus_s[1] : 1'b1;
    next_inh = (next_phy != P_SLEEP);
    // The transmitter drives only in normal mode and yields on timeout.
    next_tx  = (next_phy == P_NORMAL) ? (i_txd || dom_to) : 1'b1;
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      phy              <= P_PWRUP;
      wake_flag        <= 1'b0;
      slp_hi_d         <= 1'b0;
      o_rxd            <= 1'b1;
      o_inhibit_output <= 1'b1;
      o_bus_tx         <= 1'b1;
    end else begin
      phy              <= next_phy;
      wake_flag        <= next_wake_flag;
      slp_hi_d         <= next_slp_hi_d;
      o_rxd            <= next_rxd;
      o_inhibit_output <= next_inh;
      o_bus_tx         <= next_tx;
    end
  end
  assign o_wake_flag = wake_flag;
  assign o_phy_mode  = phy;

  // Addressing sequence: three measurements inside one break field.
  meas_e ms, next_ms;
  logic [ADC_W-1:0]  bg, next_bg;
  logic              pre_in, next_pre_in;
  logic [ADDR_W-1:0] pend, next_pend;
  logic next_cs1, next_cs2, next_start, next_far, next_av, next_fail;
  logic [ADDR_W-1:0] next_addr;

  function automatic logic over_thr(input logic [ADC_W-1:0] v,
                                    input logic [ADC_W-1:0] b,
                                    input logic [ADC_W-1:0] t);
    // Results below the background count as no excess current.
    over_thr = (v > b) && ((v - b) > t);
  endfunction

  always_comb begin
    next_ms    = ms;
    next_bg    = bg;
    next_pre_in = pre_in;
    next_pend  = pend;
    next_cs1   = o_first_source_port_pin;
    next_cs2   = o_second_source_port_pin;
    next_start = 1'b0;
    next_far   = o_farthest;
    next_av    = o_addr_valid;
    next_addr  = o_node_addr;
    next_fail  = 1'b0;
    unique case (ms)
      M_IDLE: begin
        if (i_assign_cmd) begin
          next_ms   = M_ARMED;
          next_pend = i_assign_addr;
        end
      end
      M_ARMED: begin
        if (i_break_start) begin
          next_ms    = M_MEAS1;
          next_cs1   = 1'b0;
          next_cs2   = 1'b0;
          next_start = 1'b1;
        end
      end
      M_MEAS1: begin
        if (i_adc_valid) begin
          next_bg    = i_adc_data;
          next_ms    = M_MEAS2;
          next_cs1   = 1'b1;
          next_start = 1'b1;
        end
      end
      M_MEAS2: begin
        if (i_adc_valid) begin
          next_pre_in = !over_thr(i_adc_data, bg,
                                  i_current_difference_threshold);
          next_ms    = M_MEAS3;
          next_cs1   = next_pre_in;
          next_cs2   = next_pre_in;
          next_start = 1'b1;
        end
      end
      M_MEAS3: begin
        if (i_adc_valid) begin
          next_ms  = M_DONE;
          next_cs1 = 1'b0;
          next_cs2 = 1'b0;
          next_far = pre_in && !over_thr(i_adc_data, bg,
                               i_current_difference_threshold);
          if (next_far) begin
            next_av   = 1'b1;
            next_addr = pend;
          end
        end
      end
      M_DONE: begin
        next_ms = M_IDLE;
      end
    endcase
    // A break that ends before the sequence finishes aborts the attempt.
    if (i_break_end && (ms == M_MEAS1 || ms == M_MEAS2 ||
        ms == M_MEAS3) && !(ms == M_MEAS3 && i_adc_valid)) begin
      next_ms    = M_IDLE;
      next_cs1   = 1'b0;
      next_cs2   = 1'b0;
      next_start = 1'b0;
      next_fail  = 1'b1;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ms                       <= M_IDLE;
      bg                       <= '0;
      pre_in                   <= 1'b0;
      pend                     <= '0;
      o_first_source_port_pin  <= 1'b0;
      o_second_source_port_pin <= 1'b0;
      o_adc_start              <= 1'b0;
      o_farthest               <= 1'b0;
      o_addr_valid             <= 1'b0;
      o_node_addr              <= '0;
      o_addr_fail              <= 1'b0;
    end else begin
      ms                       <= next_ms;
      bg                       <= next_bg;
      pre_in                   <= next_pre_in;
      pend                     <= next_pend;
      o_first_source_port_pin  <= next_cs1;
      o_second_source_port_pin <= next_cs2;
      o_adc_start              <= next_start;
      o_farthest               <= next_far;
      o_addr_valid             <= next_av;
      o_node_addr              <= next_addr;
      o_addr_fail              <= next_fail;
    end
  end

  sources_off_m1_a: assert property (@(posedge i_clk_sys) disable iff
    (i_sys_rst) (ms == M_MEAS1) |-> !o_first_source_port_pin &&
    !o_second_source_port_pin) else $error("sources on in meas1");
  first_only_m2_a: assert property (@(posedge i_clk_sys) disable iff
    (i_sys_rst) (ms == M_MEAS2) |-> o_first_source_port_pin &&
    !o_second_source_port_pin) else $error("bad sources meas2");
  third_sources_a: assert property (@(posedge i_clk_sys) disable iff
    (i_sys_rst) (ms == M_MEAS3) |-> (o_first_source_port_pin == pre_in)
    && (o_second_source_port_pin == pre_in)) else $error("bad meas3");
  bg_store_a: assert property (@(posedge i_clk_sys) disable iff
    (i_sys_rst) (ms == M_MEAS1 && i_adc_valid && !i_break_end) |=>
    (bg == $past(i_adc_data)) && o_adc_start) else $error("bg lost");
  far_addr_a: assert property (@(posedge i_clk_sys) disable iff
    (i_sys_rst) $rose(o_farthest) |-> o_addr_valid &&
    (o_node_addr == pend)) else $error("farthest without addr");
  break_abort_a: assert property (@(posedge i_clk_sys) disable iff
    (i_sys_rst) (ms == M_MEAS2 && i_break_end) |=> o_addr_fail &&
    (ms == M_IDLE)) else $error("no abort at break end");
  inh_sleep_a: assert property (@(posedge i_clk_sys) disable iff
    (i_sys_rst) (phy == P_SLEEP && rwake_ok) |=> (phy == P_STANDBY)
    && o_inhibit_output && !o_rxd) else $error("wake not taken");
  wake_clear_a: assert property (@(posedge i_clk_sys) disable iff
    (i_sys_rst) (phy == P_STANDBY && slp_hi && !slp_hi_d) |=>
    !wake_flag && o_rxd) else $error("wake not cleared");
  sleep_entry_a: assert property (@(posedge i_clk_sys) disable iff
    (i_sys_rst) (phy == P_NORMAL && !slp_hi) [*1] ##0 !sleep_ok |=>
    (phy == P_NORMAL)) else $error("early sleep");
  tx_release_a: assert property (@(posedge i_clk_sys) disable iff
    (i_sys_rst) dom_to && phy == P_NORMAL |=> o_bus_tx)
    else $error("dominant not released");
endmodule : bus_shunt_addressing
`default_nettype wire

// [shunt_adc_model.sv]
// Shunt current and converter model that answers each conversion start.
`timescale 1ns/1ps
`default_nettype none
module shunt_adc_model
  import bsa_pkg::*;
(
  input  wire logic             i_clk_sys,
  input  wire logic             i_start,
  input  wire logic             i_src1,
  input  wire logic             i_src2,
  input  wire logic [ADC_W-1:0] i_bg,
  input  wire logic [ADC_W-1:0] i_add1,
  input  wire logic [ADC_W-1:0] i_add2,
  output logic                  o_valid,
  output logic [ADC_W-1:0]      o_data
);
  int wait_cnt = -1;
  initial begin
    o_valid = 1'b0;
    o_data = 12'h000;
  end
  // Data flips outside the valid cycle, so a stale sample cannot pass.
  always @(negedge i_clk_sys) begin
    o_valid <= 1'b0;
    o_data <= ~o_data;
    if (i_start) begin
      wait_cnt <= 2;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end else if (wait_cnt == 0) begin
      wait_cnt <= -1;
      o_valid <= 1'b1;
      o_data <= i_bg + (i_src1 ? i_add1 : 12'h000)
                + (i_src2 ? i_add2 : 12'h000);
    end
  end
endmodule : shunt_adc_model
`default_nettype wire

// [tb_lin_bus_shunt_auto_addressing.sv]
// Self-checking bench for the bus-shunt addressing slave logic.
`timescale 1ns/1ps
`default_nettype none
module tb_lin_bus_shunt_auto_addressing;
  import bsa_pkg::*;
  logic              clk, rst, cmd, bstart, bend, valid, slp, brx;
  logic              wake_n, txd, src1, src2, start, far, avalid;
  logic              afail, bus_tx, rxd, inhibit_output, wflag, fail_seen;
  logic [ADDR_W-1:0] addr, node_addr;
  logic [ADC_W-1:0]  data, thr, bg, a1, a2;
  logic [3:0]        mode;
  logic [1:0]        srcs [0:3];
  int                nst, fails, comparisons;
  bus_shunt_addressing #(.DOM_TIMEOUT(50)) dut (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_assign_cmd(cmd),
    .i_assign_addr(addr), .i_break_start(bstart), .i_break_end(bend),
    .i_adc_valid(valid), .i_adc_data(data),
    .i_current_difference_threshold(thr), .i_sleep_control_low(slp),
    .i_bus_rx(brx), .i_wake_n(wake_n), .i_txd(txd),
    .o_first_source_port_pin(src1), .o_second_source_port_pin(src2),
    .o_adc_start(start), .o_farthest(far), .o_addr_valid(avalid),
    .o_node_addr(node_addr), .o_addr_fail(afail), .o_bus_tx(bus_tx),
    .o_rxd(rxd), .o_inhibit_output(inhibit_output), .o_wake_flag(wflag),
    .o_phy_mode(mode));
  shunt_adc_model model (
    .i_clk_sys(clk), .i_start(start), .i_src1(src1), .i_src2(src2),
    .i_bg(bg), .i_add1(a1), .i_add2(a2), .o_valid(valid), .o_data(data));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Sources are sampled in the cycle that starts each conversion.
  always @(posedge clk) begin
    if (start && nst < 4) srcs[nst] <= {src1, src2};
    if (start) nst <= nst + 1;
    if (afail) fail_seen <= 1'b1;
  end
  task test_done;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task arm(input logic [5:0] ad, input int want);
    int k;
    nst = 0;
    addr = ad;
    cmd = 1'b1;
    cyc(1);
    cmd = 1'b0;
    cyc(2);
    bstart = 1'b1;
    cyc(1);
    bstart = 1'b0;
    for (k = 0; k < 60 && nst < want; k++) cyc(1);
    if (nst < want) begin
      fails++;
      $display("mismatch arm starts expected %0d seen %0d", want, nst);
      test_done();
    end
  endtask : arm
  task seq(input logic [11:0] x1, x2, input logic [5:0] ad);
    logic pin, f;
    pin = x1 <= thr;
    f = pin && (x1 + x2 <= thr);
    a1 = x1;
    a2 = x2;
    fail_seen = 1'b0;
    arm(ad, 3);
    cyc(6);
    chk("starts", 12'h003, 12'(nst));
    chk("meas1 src", 12'h000, 12'(srcs[0]));
    chk("meas2 src", 12'h002, 12'(srcs[1]));
    chk("meas3 src", pin ? 12'h003 : 12'h000, 12'(srcs[2]));
    chk("farthest", 12'(f), 12'(far));
    if (f) chk("address", 12'(ad), 12'(node_addr));
    bend = 1'b1;
    cyc(1);
    bend = 1'b0;
    cyc(2);
    chk("no fail", 12'h000, 12'(fail_seen));
  endtask : seq
  task abort_seq;
    a1 = 12'h010;
    a2 = 12'h000;
    fail_seen = 1'b0;
    arm(6'h2A, 2);
    bend = 1'b1;
    cyc(1);
    bend = 1'b0;
    cyc(3);
    chk("fail pulse", 12'h001, 12'(fail_seen));
    chk("src off", 12'h000, {10'h000, src1, src2});
    chk("no addr", 12'h000, 12'(avalid));
  endtask : abort_seq
  task modes;
    slp = 1'b1;
    cyc(200);
    chk("early", 12'(P_PWRUP), 12'(mode));
    cyc(60);
    chk("normal", 12'(P_NORMAL), 12'(mode));
    txd = 1'b0;
    cyc(20);
    chk("tx dom", 12'h000, 12'(bus_tx));
    cyc(40);
    chk("tx free", 12'h001, 12'(bus_tx));
    txd = 1'b1;
    slp = 1'b0;
    cyc(260);
    chk("sleep", 12'(P_SLEEP), 12'(mode));
    chk("inh sleep", 12'h000, 12'(inhibit_output));
    brx = 1'b0;
    cyc(760);
    brx = 1'b1;
    chk("standby", 12'(P_STANDBY), 12'(mode));
    chk("rxd wake", 12'h000, 12'(rxd));
    chk("inh", 12'h001, 12'(inhibit_output));
    chk("flag set", 12'h001, 12'(wflag));
    slp = 1'b1;
    cyc(4);
    chk("rxd clr", 12'h001, 12'(rxd));
    chk("flag clr", 12'h000, 12'(wflag));
    cyc(260);
    chk("normal again", 12'(P_NORMAL), 12'(mode));
    slp = 1'b0;
    cyc(260);
    wake_n = 1'b0;
    cyc(185);
    wake_n = 1'b1;
    chk("local", 12'(P_STANDBY), 12'(mode));
    slp = 1'b1;
    cyc(260);
    slp = 1'b0;
    cyc(260);
    chk("sleep again", 12'(P_SLEEP), 12'(mode));
    slp = 1'b1;
    cyc(260);
    chk("direct", 12'(P_NORMAL), 12'(mode));
  endtask : modes
  initial begin
    {cmd, bstart, bend, slp, fail_seen} = '0;
    {brx, wake_n, txd, rst} = 4'hF;
    addr = 6'h00;
    thr = THR_RST;
    bg = 12'h100;
    a1 = 12'h000;
    a2 = 12'h000;
    nst = 0;
    fails = 0;
    comparisons = 0;
    cyc(5);
    rst = 1'b0;
    cyc(1);
    chk("rst mode", 12'(P_PWRUP), 12'(mode));
    chk("rst tx", 12'h001, 12'(bus_tx));
    seq(12'h041, 12'h000, 6'h11);
    seq(12'h010, 12'h031, 6'h12);
    abort_seq();
    seq(12'h040, 12'h000, 6'h15);
    thr = 12'h020;
    seq(12'h021, 12'h000, 6'h16);
    modes();
    test_done();
  end
endmodule : tb_lin_bus_shunt_auto_addressing
`default_nettype wire
